// File: pcid_defs.svh
// Register offsets, reset values and field positions of the pin change detector.
// Assumes a 32-bit Wishbone slave with one register per aligned word.
`ifndef PCID_DEFS_SVH
`define PCID_DEFS_SVH

`define PCID_OFF_PA_RISE 6'h00
`define PCID_OFF_PA_FALL 6'h04
`define PCID_OFF_PA_FLAG 6'h08
`define PCID_OFF_PB_RISE 6'h0c
`define PCID_OFF_PB_FALL 6'h10
`define PCID_OFF_PB_FLAG 6'h14
`define PCID_OFF_PC_RISE 6'h18
`define PCID_OFF_PC_FALL 6'h1c
`define PCID_OFF_PC_FLAG 6'h20
`define PCID_OFF_PE_RISE 6'h24
`define PCID_OFF_PE_FALL 6'h28
`define PCID_OFF_PE_FLAG 6'h2c
`define PCID_OFF_CTRL 6'h30
`define PCID_OFF_IRQ_STAT 6'h34
`define PCID_OFF_IRQ_MASK 6'h38

`define PCID_RESET_BYTE 8'h00
`define PCID_PE_BIT 3
`define PCID_PE_MASK 8'h08
`define PCID_CTRL_MASTER_EN 0
`define PCID_CTRL_DISABLE 1

`endif

// File: pcid_pkg.sv
// Types shared by the pin change detector.
// Assumes nothing beyond a SystemVerilog compiler.
package pcid_pkg;
  typedef enum logic [1:0] {
    PCID_PORT_A = 2'b00,
    PCID_PORT_B = 2'b01,
    PCID_PORT_C = 2'b10,
    PCID_PORT_E = 2'b11
  } pcid_port_type;
endpackage : pcid_pkg

// File: pcid_pin_change_detect.sv
// Pin change interrupt detector with a classic Wishbone register slave.
// Assumes port pins are asynchronous and are synchronised here; one clock domain.
// How it works
// - Ports A, B, C all bits and port E bit 3 are watched.
// - Master enable clear still sets flags but blocks the interrupt.
// - A rise enable bit arms a rising edge detector per pin.
// - A fall enable bit arms a falling edge detector per pin.
// - Both enables set detect either polarity together.
// - Enabled edge sets the pin flag; interrupt only with master enable.
// - Summary flag is the OR of all pin flags.
// - Writing zero clears a flag; a same-cycle edge keeps it set.
// - Detected change wakes the device when master enable is set.
// - Edges during sleep reach the flags before the CPU resumes.
// - Enable registers are eight R/W bits resetting to zero.
// - Flags are hardware-set, software-writable, zero after reset.
// - Port E registers implement only bit 3, others read zero.
// - Reset pin or low-voltage config set removes port E bit 3 detection.
// - The disable bit turns off and resets all change detection.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pcid_defs.svh"

module pcid_pin_change_detect
  import pcid_pkg::*;
#(
  parameter int PORT_WIDTH = 8
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [PORT_WIDTH-1:0] portaPins,
  input wire logic [PORT_WIDTH-1:0] portbPins,
  input wire logic [PORT_WIDTH-1:0] portcPins,
  input wire logic portePin3,
  input wire logic extResetPinCfg,
  input wire logic lowVoltProgCfg,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic changeIrq,
  output logic changeIrqSummaryFlag,
  output logic wakeRequest,
  output logic blockIrq
);

  // Each port register holds its port in data byte 0 only, so only eight pins fit;
  // any other width is refused while the design is elaborated.
  if (PORT_WIDTH != 8)
  begin : g_widthCheck
    $error("pcid_pin_change_detect supports PORT_WIDTH of 8 only");
  end

  localparam int NPIN = 4 * PORT_WIDTH;

  // Flattened per-pin views: A in 7:0, B in 15:8, C in 23:16, E in 31:24.
  logic [NPIN-1:0] pinsRaw;
  logic [NPIN-1:0] syncA_reg;
  logic [NPIN-1:0] syncB_reg;
  logic [NPIN-1:0] prevLevel_reg;
  logic [NPIN-1:0] riseEn_reg;
  logic [NPIN-1:0] fallEn_reg;
  logic [NPIN-1:0] flags_reg;
  logic [NPIN-1:0] flags_next;
  logic [NPIN-1:0] implMask;
  logic [NPIN-1:0] edgeHit;
  logic [NPIN-1:0] wrData;
  logic [NPIN-1:0] riseWr;
  logic [NPIN-1:0] fallWr;
  logic [NPIN-1:0] flagWr;
  logic masterEn_reg;
  logic disable_reg;
  logic [1:0] irqStat_reg;
  logic [1:0] irqMask_reg;
  logic [1:0] irqEvent;
  logic ack_reg;
  logic [31:0] rdData_reg;
  logic busReq;
  logic busWrite;
  logic byteLane0;
  logic porteAvail;
  pcid_port_type selPort;

  // Port E bit 3 keeps its own bit position, so all per-pin views line up by byte.
  assign pinsRaw = {{(PORT_WIDTH-1-`PCID_PE_BIT){1'b0}}, portePin3,
    {`PCID_PE_BIT{1'b0}}, portcPins, portbPins, portaPins};

  // Port E bit 3 is lost when its pin is taken for reset or programming.
  assign porteAvail = ~extResetPinCfg & ~lowVoltProgCfg;
  assign implMask = {(`PCID_PE_MASK & {PORT_WIDTH{porteAvail}}),
    {(3*PORT_WIDTH){1'b1}}};

  // Two-stage synchroniser; only the second stage feeds the detectors.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end
    else if (clkEn)
    begin
      syncA_reg <= pinsRaw;
      syncB_reg <= syncA_reg;
    end
  end

  // Previous sampled level; held at the live level while disabled so no
  // stale edge fires on re-enable.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prevLevel_reg <= '0;
    end
    else if (clkEn)
    begin
      prevLevel_reg <= syncB_reg;
    end
  end

  // Per-pin edge detection, one generate entry per pin.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1)
    begin : g_pin
      assign edgeHit[gi] = implMask[gi] & ~disable_reg &
        ((riseEn_reg[gi] & syncB_reg[gi] & ~prevLevel_reg[gi]) |
         (fallEn_reg[gi] & ~syncB_reg[gi] & prevLevel_reg[gi]));
    end
  endgenerate

  // Wishbone decode: one-cycle ack, data lanes in byte 0.
  // A request is taken only while ack is low, so a held request is not taken twice.
  assign busReq = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign busWrite = busReq & wb_we_i;
  assign byteLane0 = wb_sel_i[0];
  assign wrData = {4{wb_dat_i[7:0]}};

  always_comb
  begin
    riseWr = '0;
    fallWr = '0;
    flagWr = '0;
    selPort = PCID_PORT_A;
    case (wb_adr_i)
      `PCID_OFF_PA_RISE, `PCID_OFF_PA_FALL, `PCID_OFF_PA_FLAG: selPort = PCID_PORT_A;
      `PCID_OFF_PB_RISE, `PCID_OFF_PB_FALL, `PCID_OFF_PB_FLAG: selPort = PCID_PORT_B;
      `PCID_OFF_PC_RISE, `PCID_OFF_PC_FALL, `PCID_OFF_PC_FLAG: selPort = PCID_PORT_C;
      `PCID_OFF_PE_RISE, `PCID_OFF_PE_FALL, `PCID_OFF_PE_FLAG: selPort = PCID_PORT_E;
      default: selPort = PCID_PORT_A;
    endcase
    if (busWrite && byteLane0 && !disable_reg)
    begin
      case (wb_adr_i)
        `PCID_OFF_PA_RISE, `PCID_OFF_PB_RISE, `PCID_OFF_PC_RISE, `PCID_OFF_PE_RISE:
          riseWr[selPort*PORT_WIDTH +: PORT_WIDTH] = '1;
        `PCID_OFF_PA_FALL, `PCID_OFF_PB_FALL, `PCID_OFF_PC_FALL, `PCID_OFF_PE_FALL:
          fallWr[selPort*PORT_WIDTH +: PORT_WIDTH] = '1;
        `PCID_OFF_PA_FLAG, `PCID_OFF_PB_FLAG, `PCID_OFF_PC_FLAG, `PCID_OFF_PE_FLAG:
          flagWr[selPort*PORT_WIDTH +: PORT_WIDTH] = '1;
        default: riseWr = '0;
      endcase
    end
  end

  // Rising edge enables; the disable bit holds them in reset as well.
  // Unimplemented positions are masked on every cycle, so they always read zero.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      riseEn_reg <= '0;
    end
    else if (clkEn)
    begin
      if (disable_reg)
      begin
        riseEn_reg <= '0;
      end
      else
      begin
        riseEn_reg <= ((riseEn_reg & ~riseWr) | (wrData & riseWr)) & implMask;
      end
    end
  end

  // Falling edge enables, kept apart from the rising ones but built the same way.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fallEn_reg <= '0;
    end
    else if (clkEn)
    begin
      if (disable_reg)
      begin
        fallEn_reg <= '0;
      end
      else
      begin
        fallEn_reg <= ((fallEn_reg & ~fallWr) | (wrData & fallWr)) & implMask;
      end
    end
  end

  // Flags: a write stores the byte, then any edge this cycle sets the bit,
  // so a set always beats a clear.
  always_comb
  begin
    flags_next = ((flags_reg & ~flagWr) | (wrData & flagWr)) & implMask;
    flags_next = flags_next | edgeHit;
    if (disable_reg)
    begin
      flags_next = '0;
    end
  end

  // Flag storage; the next value already folds in write, edge and disable.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flags_reg <= '0;
    end
    else if (clkEn)
    begin
      flags_reg <= flags_next;
    end
  end

  // Control register: master enable and module disable.
  // Master enable gates only the interrupt; detection runs on with it clear.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      masterEn_reg <= 1'b0;
      disable_reg <= 1'b0;
    end
    else if (clkEn && busWrite && byteLane0 && wb_adr_i == `PCID_OFF_CTRL)
    begin
      masterEn_reg <= wb_dat_i[`PCID_CTRL_MASTER_EN];
      disable_reg <= wb_dat_i[`PCID_CTRL_DISABLE];
    end
  end

  // Summary and interrupt outputs; the summary is combinational so it falls
  // in the same cycle as the last flag.
  assign changeIrqSummaryFlag = |flags_reg;
  assign changeIrq = changeIrqSummaryFlag & masterEn_reg;
  // Wake is taken from the flag register itself, so the flag is already
  // visible when the CPU resumes.
  assign wakeRequest = changeIrq;

  // Block interrupt events: bit 0 any new edge, bit 1 a write to a port
  // register while disabled (the write is dropped).
  assign irqEvent[0] = |edgeHit;
  assign irqEvent[1] = busWrite & disable_reg & (wb_adr_i < `PCID_OFF_CTRL);

  // Block status: write-one-to-clear, with a new event winning over its clear.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqStat_reg <= 2'h0;
    end
    else if (clkEn)
    begin
      if (busWrite && byteLane0 && wb_adr_i == `PCID_OFF_IRQ_STAT)
      begin
        irqStat_reg <= (irqStat_reg & ~wb_dat_i[1:0]) | irqEvent;
      end
      else
      begin
        irqStat_reg <= irqStat_reg | irqEvent;
      end
    end
  end

  // Block mask, plain read and write with the same layout as the status.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqMask_reg <= 2'h0;
    end
    else if (clkEn && busWrite && byteLane0 && wb_adr_i == `PCID_OFF_IRQ_MASK)
    begin
      irqMask_reg <= wb_dat_i[1:0];
    end
  end

  // Block interrupt level, high while any unmasked status bit is set.
  assign blockIrq = |(irqStat_reg & irqMask_reg);

  // Read data and ack, registered; port registers read zero while disabled.
  // Reads have no side effect, which keeps the read, invert and AND clear safe.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_reg <= 1'b0;
      rdData_reg <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      ack_reg <= busReq;
      rdData_reg <= 32'h0000_0000;
      if (busReq && !wb_we_i)
      begin
        case (wb_adr_i)
          `PCID_OFF_PA_RISE, `PCID_OFF_PB_RISE, `PCID_OFF_PC_RISE, `PCID_OFF_PE_RISE:
            rdData_reg[7:0] <= riseEn_reg[selPort*PORT_WIDTH +: PORT_WIDTH];
          `PCID_OFF_PA_FALL, `PCID_OFF_PB_FALL, `PCID_OFF_PC_FALL, `PCID_OFF_PE_FALL:
            rdData_reg[7:0] <= fallEn_reg[selPort*PORT_WIDTH +: PORT_WIDTH];
          `PCID_OFF_PA_FLAG, `PCID_OFF_PB_FLAG, `PCID_OFF_PC_FLAG, `PCID_OFF_PE_FLAG:
            rdData_reg[7:0] <= flags_reg[selPort*PORT_WIDTH +: PORT_WIDTH];
          `PCID_OFF_CTRL:
            rdData_reg[1:0] <= {disable_reg, masterEn_reg};
          `PCID_OFF_IRQ_STAT:
            rdData_reg[2:0] <= {changeIrqSummaryFlag, irqStat_reg};
          `PCID_OFF_IRQ_MASK:
            rdData_reg[1:0] <= irqMask_reg;
          default:
            rdData_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Both bus outputs come straight from flip-flops.
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

endmodule : pcid_pin_change_detect
`default_nettype wire

// File: pcid_checker_sva.sv
// Concurrent checks on the bus and interrupt ports of the pin change detector.
// Assumes one clock domain; bound onto every detector instance.
`timescale 1ns/10ps
`default_nettype none

module pcid_checker_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic changeIrq,
  input wire logic changeIrqSummaryFlag,
  input wire logic wakeRequest,
  input wire logic extResetPinCfg,
  input wire logic lowVoltProgCfg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_ackOne; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackOne: assert property (p_ackOne) else $error("ack held past one cycle");
  property p_ackReq; wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o; endproperty
  a_ackReq: assert property (p_ackReq) else $error("request not acked next cycle");
  property p_ackCause; !(wb_cyc_i && wb_stb_i) && clkEn |=> !wb_ack_o; endproperty
  a_ackCause: assert property (p_ackCause) else $error("ack without request");
  property p_datIdle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_datIdle: assert property (p_datIdle) else $error("read data outside ack");
  property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper data bits set");
  property p_irqFlag; changeIrq |-> changeIrqSummaryFlag; endproperty
  a_irqFlag: assert property (p_irqFlag) else $error("irq with no flag");
  property p_wake; wakeRequest == changeIrq; endproperty
  a_wake: assert property (p_wake) else $error("wake differs from irq");
  // Flags fall only through software: a flag write shows on its own ack edge, a
  // disable write one edge later; a port E config change may also drop its flag.
  property p_sumFall;
    $fell(changeIrqSummaryFlag) |-> (wb_ack_o && wb_we_i) ||
      ($past(wb_ack_o) && $past(wb_we_i)) || $past(extResetPinCfg) || $past(lowVoltProgCfg);
  endproperty
  a_sumFall: assert property (p_sumFall) else $error("flag fell with no write");
endmodule : pcid_checker_sva

bind pcid_pin_change_detect pcid_checker_sva i_chk (.clk(clk), .reset_n(reset_n),
  .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .changeIrq(changeIrq),
  .changeIrqSummaryFlag(changeIrqSummaryFlag), .wakeRequest(wakeRequest),
  .extResetPinCfg(extResetPinCfg), .lowVoltProgCfg(lowVoltProgCfg));
`default_nettype wire

// File: pcid_pin_model.sv
// Behavioural model of the port pins feeding the detector.
// Assumes only the bench's main sequence calls drive.
`timescale 1ns/10ps
`default_nettype none

module pcid_pin_model (
  input wire logic clk,
  output logic [7:0] portaPins,
  output logic [7:0] portbPins,
  output logic [7:0] portcPins,
  output logic portePin3
);
  // Pins are strapped low at start so no edge is seen out of reset.
  initial
  begin
    portaPins = 8'h00;
    portbPins = 8'h00;
    portcPins = 8'h00;
    portePin3 = 1'b0;
  end

  // Levels change just after an edge; the task then waits w further edges before returning.
  task automatic drive(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
    input logic e, input int w);
    @(posedge clk);
    portaPins <= a;
    portbPins <= b;
    portcPins <= c;
    portePin3 <= e;
    repeat (w) @(posedge clk);
  endtask : drive
endmodule : pcid_pin_model
`default_nettype wire

// File: pcid_tb.sv
// Self-checking bench for the pin change detector over classic Wishbone.
// Assumes the pin model and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "pcid_defs.svh"

module tb;
  logic clk, reset_n, cyc, stb, we, ack, irq, sum, wake, blk, extCfg, lvpCfg, pe, en;
  logic [5:0] adr;
  logic [31:0] wdat, rdat;
  logic [7:0] pa, pb, pc, r, f;
  logic [31:0] expQ[$];
  int fails, samples_checked;

  pcid_pin_model i_pins (.clk(clk), .portaPins(pa), .portbPins(pb), .portcPins(pc),
    .portePin3(pe));
  pcid_pin_change_detect i_dut (.clk(clk), .reset_n(reset_n), .clkEn(en),
    .portaPins(pa), .portbPins(pb), .portcPins(pc), .portePin3(pe),
    .extResetPinCfg(extCfg), .lowVoltProgCfg(lvpCfg), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .changeIrq(irq), .changeIrqSummaryFlag(sum), .wakeRequest(wake),
    .blockIrq(blk));

  // System clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic close_out;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask : cmp

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40)
    begin
      fails++;
      close_out();
    end
  endtask : wb

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    wb(1'b0, a, 8'h00);
  endtask : rd

  // Read data is judged at the ack edge against the oldest expectation.
  always @(posedge clk)
    if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0)
      cmp("rdata", expQ.pop_front(), rdat);

  initial
  begin
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    wdat = 32'h0;
    extCfg = 1'b0;
    lvpCfg = 1'b0;
    en = 1'b1;
    void'($urandom(32'hf42f));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 64; a += 4)
      rd(6'(a), 8'h00);
    r = 8'($urandom()) | 8'h01;
    f = 8'($urandom()) | 8'h02;
    wb(1'b1, `PCID_OFF_PA_RISE, r);
    rd(`PCID_OFF_PA_RISE, r);
    wb(1'b1, `PCID_OFF_PE_RISE, 8'hff);
    rd(`PCID_OFF_PE_RISE, `PCID_PE_MASK);
    i_pins.drive(8'hff, 8'h5a, 8'h00, 1'b1, 4);
    rd(`PCID_OFF_PA_FLAG, r);
    rd(`PCID_OFF_PE_FLAG, `PCID_PE_MASK);
    cmp("irq", 1'b0, irq);
    wb(1'b1, `PCID_OFF_PA_FLAG, (r ^ 8'hff) & r);
    rd(`PCID_OFF_PA_FLAG, 8'h00);
    cmp("summary", 1'b1, sum);
    wb(1'b1, `PCID_OFF_PE_FLAG, 8'h00);
    cmp("summary", 1'b0, sum);
    wb(1'b1, `PCID_OFF_PA_RISE, 8'h00);
    wb(1'b1, `PCID_OFF_PA_FALL, f);
    wb(1'b1, `PCID_OFF_PB_RISE, 8'hff);
    wb(1'b1, `PCID_OFF_PB_FALL, 8'hff);
    i_pins.drive(8'h00, 8'h00, 8'h00, 1'b1, 4);
    rd(`PCID_OFF_PA_FLAG, f);
    wb(1'b1, `PCID_OFF_PB_FLAG, 8'h00);
    i_pins.drive(8'h00, 8'h5a, 8'h00, 1'b1, 4);
    rd(`PCID_OFF_PB_FLAG, 8'h5a);
    wb(1'b1, `PCID_OFF_CTRL, 8'h01);
    cmp("irq", 1'b1, irq);
    cmp("wake", 1'b1, wake);
    rd(`PCID_OFF_IRQ_STAT, 8'h05);
    wb(1'b1, `PCID_OFF_IRQ_MASK, 8'h01);
    cmp("block", 1'b1, blk);
    wb(1'b1, `PCID_OFF_IRQ_STAT, 8'h01);
    cmp("block", 1'b0, blk);
    // The clear lands on the very edge that the new pin edge sets the flag.
    wb(1'b1, `PCID_OFF_PC_RISE, 8'h01);
    i_pins.drive(8'h00, 8'h5a, 8'h01, 1'b1, 1);
    wb(1'b1, `PCID_OFF_PC_FLAG, 8'h00);
    rd(`PCID_OFF_PC_FLAG, 8'h01);
    extCfg <= 1'b1;
    rd(`PCID_OFF_PE_RISE, 8'h00);
    extCfg <= 1'b0;
    lvpCfg <= 1'b1;
    wb(1'b1, `PCID_OFF_PE_FALL, 8'h08);
    rd(`PCID_OFF_PE_FALL, 8'h00);
    lvpCfg <= 1'b0;
    wb(1'b1, `PCID_OFF_CTRL, 8'h03);
    // Disable clears the flags one edge after the control write lands.
    @(posedge clk);
    cmp("summary", 1'b0, sum);
    wb(1'b1, `PCID_OFF_PA_RISE, 8'hff);
    wb(1'b1, `PCID_OFF_CTRL, 8'h01);
    rd(`PCID_OFF_PA_RISE, 8'h00);
    rd(`PCID_OFF_IRQ_STAT, 8'h03);
    // Clock enable low freezes the synchroniser, so a pin edge waits for it.
    wb(1'b1, `PCID_OFF_PC_RISE, 8'h02);
    en <= 1'b0;
    i_pins.drive(8'h00, 8'h5a, 8'h03, 1'b1, 4);
    cmp("frozen", 1'b0, sum);
    en <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`PCID_OFF_PC_FLAG, 8'h02);
    close_out();
  end
endmodule : tb
`default_nettype wire
